// ### design/drive_control_source_config.sv
// Parameter bank that selects control source, local start-up mode and position port role.
`timescale 1ns/100ps
`default_nettype none
module drive_control_source_config
    import drive_cfg_pkg::*;
(
    // Clock and reset.
    input  wire  logic            i_clk,
    input  wire  logic            i_srst,
    // Parameter access from the fieldbus.
    input  wire  param_req_s      i_req,
    output logic                  o_rsp_valid,
    output logic                  o_rsp_err,
    output logic [15:0]           o_rsp_data,
    // Drive state.
    input  wire  logic            i_power_on,
    input  wire  logic            i_operation_enabled_state,
    // Active configuration.
    output control_source_e       o_control_source,
    output port_role_e            o_port_role,
    output logic                  o_quadrature_input_role,
    output logic                  o_step_direction_input_role,
    output logic                  o_encoder_emulation_output_role,
    output logic                  o_local_start,
    output startup_mode_e         o_local_start_mode
);

    // Stored values stand for the retained copies; active values are what the drive runs on.
    control_source_e src_stored_r;
    control_source_e src_stored_nxt;
    port_role_e      port_stored_r;
    port_role_e      port_stored_nxt;
    startup_mode_e   mode_stored_r;
    startup_mode_e   mode_stored_nxt;
    control_source_e src_active_nxt;
    port_role_e      port_active_nxt;
    logic            op_en_d_r;

    // Address decode and range checks.
    logic            hit_src;
    logic            hit_port;
    logic            hit_mode;
    logic            hit_any;
    logic            is_read;
    logic            ok_src;
    logic            ok_port;
    logic            ok_mode;

    // Accepted and rejected writes.
    logic            wr_src;
    logic            wr_port;
    logic            wr_mode;
    logic            wr_bad;
    logic [1:0]      new_code;
    logic            src_now;

    // Read path, start detection and answer.
    logic [15:0]     rd_value;
    logic            op_en_rise;
    logic            start_now;
    logic            start_pulse_nxt;
    logic [2:0]      role_hot_nxt;
    param_rsp_s      rsp_nxt;

    assign hit_src  = i_req.addr == ADDR_CONTROL_SOURCE;
    assign hit_port = i_req.addr == ADDR_POSITION_PORT;
    assign hit_mode = i_req.addr == ADDR_STARTUP_MODE;
    assign hit_any  = hit_src | hit_port | hit_mode;
    assign is_read  = i_req.rd & ~i_req.wr;

    assign ok_src   = i_req.data <= MAX_CONTROL_SOURCE;
    assign ok_port  = i_req.data <= MAX_POSITION_PORT;
    assign ok_mode  = i_req.data <= MAX_STARTUP_MODE;

    assign wr_src   = i_req.wr & hit_src & ok_src;
    assign wr_port  = i_req.wr & hit_port & ok_port;
    assign wr_mode  = i_req.wr & hit_mode & ok_mode;
    assign wr_bad   = i_req.wr & ~(wr_src | wr_port | wr_mode);

    // Only two bits can be nonzero once the range check has passed.
    assign new_code = i_req.data[1:0];

    // Leaving undefined during first setup must not wait for a power cycle.
    assign src_now  = wr_src & (o_control_source == SRC_UNDEFINED) & (new_code != 2'b00);

    assign rd_value = hit_src  ? {14'h0000, src_stored_r}  :
                      hit_port ? {14'h0000, port_stored_r} :
                      hit_mode ? {14'h0000, mode_stored_r} : 16'h0000;

    assign src_stored_nxt  = wr_src  ? control_source_e'(new_code) : src_stored_r;
    assign port_stored_nxt = wr_port ? port_role_e'(new_code)      : port_stored_r;
    assign mode_stored_nxt = wr_mode ? startup_mode_e'(new_code)   : mode_stored_r;

    // The immediate first-setup write wins over a power-on in the same cycle.
    assign src_active_nxt  = src_now    ? control_source_e'(new_code) :
                             i_power_on ? src_stored_r                : o_control_source;
    assign port_active_nxt = i_power_on ? port_stored_r : o_port_role;

    // The start-up mode is not latched at power-on, so a new value applies at the next enable.
    assign op_en_rise      = i_operation_enabled_state & ~op_en_d_r;
    assign start_now       = op_en_rise & (o_control_source == SRC_LOCAL_IO_CONTROL);
    assign start_pulse_nxt = start_now & (mode_stored_r != MODE_NONE);

    // One decoder bit per port role, so a code that no role owns enables none.
    for (genvar g = 0; g < 3; g++) begin : g_role
        assign role_hot_nxt[g] = o_port_role == port_role_e'(2'(g));
    end

    assign rsp_nxt.valid = i_req.wr | i_req.rd;
    assign rsp_nxt.err   = wr_bad | (is_read & ~hit_any);
    assign rsp_nxt.data  = is_read ? rd_value : 16'h0000;

    // Stored copies, updated only by accepted writes.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            src_stored_r <= RESET_CONTROL_SOURCE;
        end else begin
            src_stored_r <= src_stored_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            port_stored_r <= RESET_POSITION_PORT;
        end else begin
            port_stored_r <= port_stored_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_stored_r <= RESET_STARTUP_MODE;
        end else begin
            mode_stored_r <= mode_stored_nxt;
        end
    end

    // Active copies follow the stored ones at power-on.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_control_source <= RESET_CONTROL_SOURCE;
        end else begin
            o_control_source <= src_active_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_port_role <= RESET_POSITION_PORT;
        end else begin
            o_port_role <= port_active_nxt;
        end
    end

    // Decoded port roles lag the active role by one cycle.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_quadrature_input_role <= 1'b1;
        end else begin
            o_quadrature_input_role <= role_hot_nxt[0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_step_direction_input_role <= 1'b0;
        end else begin
            o_step_direction_input_role <= role_hot_nxt[1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_encoder_emulation_output_role <= 1'b0;
        end else begin
            o_encoder_emulation_output_role <= role_hot_nxt[2];
        end
    end

    // Automatic start of the local mode.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            op_en_d_r <= 1'b0;
        end else begin
            op_en_d_r <= i_operation_enabled_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_local_start <= 1'b0;
        end else begin
            o_local_start <= start_pulse_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_local_start_mode <= RESET_STARTUP_MODE;
        end else if (start_now) begin
            o_local_start_mode <= mode_stored_r;
        end
    end

    // Access answer, one cycle after the request.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rsp_valid <= 1'b0;
        end else begin
            o_rsp_valid <= rsp_nxt.valid;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rsp_err <= 1'b0;
        end else begin
            o_rsp_err <= rsp_nxt.err;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rsp_data <= 16'h0000;
        end else begin
            o_rsp_data <= rsp_nxt.data;
        end
    end

endmodule // drive_control_source_config
`default_nettype wire

// ### shared/drive_cfg_pkg.sv
// Constants, types and register map of the drive control source configuration block.
// Operation
// - The control source code is 0 for undefined after reset, 1 for local I/O, 2 for CAN fieldbus and 3 for serial fieldbus.
// - A new control source value becomes active at the next power-on, except that leaving an active value of 0 applies at once.
// - The local start-up mode code is 0 for none, 1 for torque loop and 2 for velocity loop on the analog reference, and 3 for electronic gearing.
// - The selected local start-up mode is started when the drive enters the operation enabled state while local I/O control is active.
// - The position port code is 0 for quadrature input with fourfold evaluation, 1 for step and direction input with gate, and 2 for encoder emulation output.
// - The position port role defaults to quadrature input and a new value becomes active at the next power-on.
// - The three parameters are 16-bit unsigned, readable and writable, retained over power cycles and found at fixed addresses.
package drive_cfg_pkg;

    localparam logic [15:0] ADDR_CONTROL_SOURCE = 16'h0502;
    localparam logic [15:0] ADDR_POSITION_PORT  = 16'h0504;
    localparam logic [15:0] ADDR_STARTUP_MODE   = 16'h0506;

    localparam logic [15:0] MAX_CONTROL_SOURCE  = 16'h0003;
    localparam logic [15:0] MAX_POSITION_PORT   = 16'h0002;
    localparam logic [15:0] MAX_STARTUP_MODE    = 16'h0003;

    typedef enum logic [1:0] {
        SRC_UNDEFINED              = 2'b00,
        SRC_LOCAL_IO_CONTROL       = 2'b01,
        SRC_CAN_FIELDBUS_CONTROL   = 2'b10,
        SRC_SERIAL_FIELDBUS_CONTROL = 2'b11
    } control_source_e;

    typedef enum logic [1:0] {
        MODE_NONE                    = 2'b00,
        MODE_TORQUE_LOOP             = 2'b01,
        MODE_VELOCITY_LOOP           = 2'b10,
        MODE_ELECTRONIC_GEARING      = 2'b11
    } startup_mode_e;

    typedef enum logic [1:0] {
        ROLE_QUADRATURE_INPUT        = 2'b00,
        ROLE_STEP_DIRECTION_INPUT    = 2'b01,
        ROLE_ENCODER_EMULATION_OUTPUT = 2'b10
    } port_role_e;

    localparam control_source_e RESET_CONTROL_SOURCE = SRC_UNDEFINED;
    localparam port_role_e      RESET_POSITION_PORT  = ROLE_QUADRATURE_INPUT;
    localparam startup_mode_e   RESET_STARTUP_MODE   = MODE_NONE;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] data;
    } param_req_s;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } param_rsp_s;

endpackage

// ### tb/drive_cfg_checker.sv
// Port assertions for the control source configuration bank.
`timescale 1ns/100ps
`default_nettype none
module drive_cfg_checker import drive_cfg_pkg::*; (
    input wire logic i_clk, i_srst, i_power_on, i_operation_enabled_state,
    input wire param_req_s i_req,
    input wire logic o_rsp_valid, o_rsp_err, o_local_start,
    input wire logic [15:0] o_rsp_data,
    input wire control_source_e o_control_source,
    input wire port_role_e o_port_role,
    input wire logic o_quadrature_input_role, o_step_direction_input_role,
    input wire logic o_encoder_emulation_output_role,
    input wire startup_mode_e o_local_start_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    rsp_timing_a: assert property (o_rsp_valid == $past(i_req.wr | i_req.rd))
        else $error("response timing wrong");
    data_range_a: assert property (i_req.wr && i_req.data > 16'h3 |=> o_rsp_err)
        else $error("out of range write accepted");
    read_width_a: assert property (o_rsp_valid |-> o_rsp_data[15:2] == 14'h0)
        else $error("read data too wide");
    port_hold_a: assert property ($changed(o_port_role) |-> $past(i_power_on))
        else $error("port role changed without power-on");
    src_hold_a: assert property ($changed(o_control_source) |-> $past(i_power_on) ||
        $past(o_control_source) == SRC_UNDEFINED) else $error("source changed early");
    role_decode_a: assert property ({o_encoder_emulation_output_role,
        o_step_direction_input_role, o_quadrature_input_role} == 3'h1 << $past(o_port_role))
        else $error("role decode wrong");
    start_cause_a: assert property (o_local_start |->
        $past(o_control_source) == SRC_LOCAL_IO_CONTROL && $past(i_operation_enabled_state)
        && !$past(i_operation_enabled_state, 2)) else $error("start without cause");
    start_mode_a: assert property (o_local_start |-> o_local_start_mode != MODE_NONE)
        else $error("start with no mode");
    cover property (o_local_start);
    cover property (o_rsp_valid && o_rsp_err);
    cover property ($changed(o_port_role));
endmodule // drive_cfg_checker
`default_nettype wire

// ### tb/fieldbus_master.sv
// Fieldbus master model issuing single parameter accesses.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master import drive_cfg_pkg::*; (
    input wire logic        i_clk,
    input wire logic        i_rsp_valid,
    input wire logic        i_rsp_err,
    input wire logic [15:0] i_rsp_data,
    output var param_req_s  o_req
);
    localparam logic [6:0] NODE_ADDR = 7'h01; // One unit on the segment
    initial o_req = '0;
    task automatic access(input logic w, input logic [15:0] a, d,
                          output logic e, output logic [15:0] q, output logic ok);
        @(posedge i_clk);
        o_req <= '{wr: w, rd: !w, addr: a, data: d};
        @(posedge i_clk);
        // An idle bus shows no stale word, so a late sample cannot match by luck.
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
        #1;
        ok = i_rsp_valid;
        e = i_rsp_err;
        q = i_rsp_data;
    endtask
endmodule // fieldbus_master
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the control source configuration bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import drive_cfg_pkg::*;
    logic i_clk = 1'b0, i_srst = 1'b1, i_power_on = 1'b0, i_operation_enabled_state = 1'b0;
    param_req_s i_req;
    logic o_rsp_valid, o_rsp_err, o_local_start, e, ok;
    logic o_quadrature_input_role, o_step_direction_input_role, o_encoder_emulation_output_role;
    logic [15:0] o_rsp_data, q, x, p;
    control_source_e o_control_source;
    port_role_e o_port_role;
    startup_mode_e o_local_start_mode;
    int miscompares = 0, compares = 0;
    always #4 i_clk = ~i_clk;
    drive_control_source_config u_drive_control_source_config (.*);
    fieldbus_master u_fieldbus_master (.i_clk, .i_rsp_valid(o_rsp_valid),
        .i_rsp_err(o_rsp_err), .i_rsp_data(o_rsp_data), .o_req(i_req));
    task automatic conclude();
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] xv, g);
        compares++;
        if (g !== xv) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, xv, g);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, d, input logic xe, input logic [15:0] xq);
        u_fieldbus_master.access(w, a, d, e, q, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            conclude();
        end
        chk("rsp_err", {15'h0, xe}, {15'h0, e});
        chk("rsp_data", xq, q);
    endtask
    // Activation lags one registered stage behind the power-on pulse, and decode lags one more stage behind activation.
    task automatic pulse();
        @(posedge i_clk);
        i_power_on <= 1'b1;
        @(posedge i_clk);
        i_power_on <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic start(input logic [15:0] xs, xm);
        @(posedge i_clk);
        i_operation_enabled_state <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("local_start", xs, {15'h0, o_local_start});
        chk("start_mode", xm, {14'h0, o_local_start_mode});
        @(posedge i_clk);
        i_operation_enabled_state <= 1'b0;
    endtask
    initial begin
        p = 16'h0;
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        acc(0, ADDR_CONTROL_SOURCE, 0, 0, 0);
        acc(0, ADDR_POSITION_PORT, 0, 0, 0);
        acc(0, ADDR_STARTUP_MODE, 0, 0, 0);
        acc(0, 16'h0508, 0, 1, 0);
        acc(1, 16'h0508, 16'h1, 1, 0);
        for (int v = 0; v < 4; v++) begin
            x = (v > 2) ? 16'h2 : 16'(v);
            acc(1, ADDR_POSITION_PORT, 16'(v), v > 2, 0);
            acc(0, ADDR_POSITION_PORT, 0, 0, x);
            chk("role_held", p, {14'h0, o_port_role});
            pulse();
            chk("port_role", x, {14'h0, o_port_role});
            chk("role_decode", 16'h1 << x, {13'h0, o_encoder_emulation_output_role,
                o_step_direction_input_role, o_quadrature_input_role});
            p = x;
        end
        acc(1, ADDR_CONTROL_SOURCE, 16'h4, 1, 0);
        acc(1, ADDR_CONTROL_SOURCE, 16'h1, 0, 0);
        chk("src_now", 16'h1, {14'h0, o_control_source});
        acc(1, ADDR_CONTROL_SOURCE, 16'h3, 0, 0);
        chk("src_held", 16'h1, {14'h0, o_control_source});
        acc(1, ADDR_CONTROL_SOURCE, 16'h1, 0, 0);
        for (int m = 0; m < 4; m++) begin
            acc(1, ADDR_STARTUP_MODE, 16'(m), 0, 0);
            start(16'(m != 0), 16'(m));
        end
        acc(1, ADDR_CONTROL_SOURCE, 16'h2, 0, 0);
        pulse();
        chk("src_power_on", 16'h2, {14'h0, o_control_source});
        start(0, 3);
        conclude();
    end
endmodule // tb
bind drive_control_source_config drive_cfg_checker u_drive_cfg_checker (.*);
`default_nettype wire
